// *** swer_pkg.sv ***
// Constants for the sleep/wake event router.
// Assumes a single 25 MHz clock and a word-wide register port from the control interface.
package swer_pkg;
   // Register indices on the control port
   localparam logic [15:0] WAKE_SEL_ADDR  = 16'h0040;
   localparam logic [15:0] SEQ_SEL_ADDR   = 16'h0041;
   localparam logic [15:0] TRIG_FLG_ADDR  = 16'h0D50;
   localparam logic [15:0] IRQ_MASK_ADDR  = 16'h0D51;
   localparam logic [15:0] CORE_CTRL_ADDR = 16'h0D52;
   // Field positions: six event bits occupy 7..2
   localparam int EV_LO = 2;
   localparam int EV_HI = 7;
   localparam int JACK_RISE_BIT  = 2;
   localparam int JACK_FALL_BIT  = 3;
   localparam int PIN_RISE_BIT   = 4;
   localparam int PIN_FALL_BIT   = 5;
   localparam int CLAMP_RISE_BIT = 6;
   localparam int CLAMP_FALL_BIT = 7;
   localparam int CORE_EN_BIT    = 0;
   // Reset values
   localparam logic [5:0]  SEL_RST      = 6'h00;
   localparam logic [5:0]  MASK_RST     = 6'h3F;
   localparam logic        CORE_EN_RST  = 1'b1;
   localparam logic [15:0] RD_ZERO      = 16'h0000;
   typedef enum logic {SWER_SLEEP, SWER_RUN} swer_pwr_type;
endpackage : swer_pkg

// *** swer_router.sv ***
// Sleep/wake event router: latches edges of three always-on signals and routes them.
// Assumes synchronous, de-bounced inputs and a single-cycle register write/read port.

module swer_router import swer_pkg::*; (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Always-on signals
   input  wire logic        jack_detect_signal,
   input  wire logic        pin_wake_signal,
   input  wire logic        mic_clamp_status,
   input  wire logic        regulator_enable_pin,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   // Sequencer side
   input  wire logic        seq_wr_core_off,
   output logic             seq_request,
   output logic      [5:0]  seq_event,
   // Power and interrupt
   output logic             core_regulator_on,
   output logic             in_sleep,
   output logic             irq_request
);
   logic [5:0]   wake_sel_r;
   logic [5:0]   seq_sel_r;
   logic [5:0]   irq_mask_r;
   logic [5:0]   flags_r;
   logic [5:0]   flags_nxt;
   logic [2:0]   sig_prev_r;
   logic [5:0]   edge_set;
   logic [5:0]   new_set;
   logic         core_en_r;
   logic         wake_req;
   logic         wake_cyc;
   swer_pwr_type pwr_r;
   logic [15:0]  rdata_r;
   logic         seq_req_r;
   logic [5:0]   seq_ev_r;
   logic [5:0]   clr_mask;

   // Sample previous levels for edge detection; pin stays live in sleep.
   // Sampled in reset too, so a signal already high at release is not taken as an edge.
   always_ff @(posedge clk) begin
      sig_prev_r <= {mic_clamp_status, pin_wake_signal, jack_detect_signal};
   end

   // Edges in bit order jack rise, jack fall, pin rise, pin fall, clamp rise, clamp fall
   always_comb begin
      edge_set[JACK_RISE_BIT-EV_LO]  = jack_detect_signal & ~sig_prev_r[0];
      edge_set[JACK_FALL_BIT-EV_LO]  = ~jack_detect_signal & sig_prev_r[0];
      edge_set[PIN_RISE_BIT-EV_LO]   = pin_wake_signal & ~sig_prev_r[1];
      edge_set[PIN_FALL_BIT-EV_LO]   = ~pin_wake_signal & sig_prev_r[1];
      edge_set[CLAMP_RISE_BIT-EV_LO] = mic_clamp_status & ~sig_prev_r[2];
      edge_set[CLAMP_FALL_BIT-EV_LO] = ~mic_clamp_status & sig_prev_r[2];
   end

   // Write-one-to-clear; a simultaneous edge wins so no event is lost
   assign clr_mask  = (reg_wr && reg_addr == TRIG_FLG_ADDR) ? reg_wdata[EV_HI:EV_LO] : 6'h00;
   assign flags_nxt = (flags_r & ~clr_mask) | edge_set;
   assign new_set   = edge_set & ~flags_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_r <= SEL_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_sel_r <= SEL_RST;
         seq_sel_r  <= SEL_RST;
         irq_mask_r <= MASK_RST;
      end else if (reg_wr) begin
         if (reg_addr == WAKE_SEL_ADDR) wake_sel_r <= reg_wdata[EV_HI:EV_LO];
         if (reg_addr == SEQ_SEL_ADDR)  seq_sel_r  <= reg_wdata[EV_HI:EV_LO];
         if (reg_addr == IRQ_MASK_ADDR) irq_mask_r <= reg_wdata[EV_HI:EV_LO];
      end
   end

   // Wake request: selected flags, or the enable pin overriding selection
   assign wake_req = (|(flags_r & wake_sel_r)) | regulator_enable_pin;
   assign wake_cyc = (pwr_r == SWER_SLEEP) && wake_req;

   // Core enable bit: host writes it; sequencer may clear it only with pin low
   always_ff @(posedge clk) begin
      if (rst) begin
         core_en_r <= CORE_EN_RST;
      end else if (reg_wr && reg_addr == CORE_CTRL_ADDR) begin
         core_en_r <= reg_wdata[CORE_EN_BIT];
      end else if (seq_wr_core_off && !regulator_enable_pin) begin
         core_en_r <= 1'b0;
      end
   end

   // Power state: sleep is held off by the enable bit or a live wake request
   always_ff @(posedge clk) begin
      if (rst) begin
         pwr_r <= SWER_RUN;
      end else begin
         unique case (pwr_r)
            SWER_SLEEP: if (wake_req) pwr_r <= SWER_RUN;
            SWER_RUN:   if (!core_en_r && !wake_req) pwr_r <= SWER_SLEEP;
         endcase
      end
   end

   assign core_regulator_on = (pwr_r == SWER_RUN);
   assign in_sleep          = (pwr_r == SWER_SLEEP);

   // Sequence scheduling, one pulse per run cycle that newly sets selected flags, never on a wake
   always_ff @(posedge clk) begin
      if (rst) begin
         seq_req_r <= 1'b0;
         seq_ev_r  <= 6'h00;
      end else begin
         seq_req_r <= (pwr_r == SWER_RUN) && !wake_cyc && |(new_set & seq_sel_r);
         seq_ev_r  <= new_set & seq_sel_r;
      end
   end
   assign seq_request = seq_req_r;
   assign seq_event   = seq_ev_r;

   // Interrupt: unmasked flags (mask bit 1 blocks), all edges including pin
   assign irq_request = |(flags_r & ~irq_mask_r);

   // Register readback, unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= RD_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            WAKE_SEL_ADDR:  rdata_r <= {8'h00, wake_sel_r, 2'b00};
            SEQ_SEL_ADDR:   rdata_r <= {8'h00, seq_sel_r, 2'b00};
            TRIG_FLG_ADDR:  rdata_r <= {8'h00, flags_r, 2'b00};
            IRQ_MASK_ADDR:  rdata_r <= {8'h00, irq_mask_r, 2'b00};
            CORE_CTRL_ADDR: rdata_r <= {15'h0000, core_en_r};
            default:        rdata_r <= RD_ZERO;
         endcase
      end
   end
   assign reg_rdata = rdata_r;

   // Checks, all on the one clock and silenced while reset is held.
   // Most of them look one edge ahead, so they also catch a register that
   // is right in value but a cycle late.

   // A selected latched flag ends sleep on the next edge
   a_wake_exit: assert property (@(posedge clk) disable iff (rst)
      (pwr_r == SWER_SLEEP && |(flags_r & wake_sel_r)) |=> pwr_r == SWER_RUN)
      else $error("selected flag did not wake");

   // The enable pin wakes whatever the select register holds
   a_pin_wake: assert property (@(posedge clk) disable iff (rst)
      (pwr_r == SWER_SLEEP && regulator_enable_pin) |=> core_regulator_on)
      else $error("enable pin did not wake");

   // A sequence pulse never comes from sleep or from the wake cycle
   a_seq_no_sleep: assert property (@(posedge clk) disable iff (rst)
      seq_request |-> $past(pwr_r) == SWER_RUN && !$past(wake_cyc))
      else $error("sequence from sleep or wake");

   // A newly set selected flag in normal operation schedules a sequence
   a_seq_fires: assert property (@(posedge clk) disable iff (rst)
      (pwr_r == SWER_RUN && |(edge_set & ~flags_r & seq_sel_r)) |=> seq_request)
      else $error("selected new flag missed sequence");

   // A jack rise sets its flag on the next edge
   a_flag_set: assert property (@(posedge clk) disable iff (rst)
      (jack_detect_signal && !sig_prev_r[0]) |=> flags_r[0])
      else $error("jack rise flag not set");

   // Writing one clears a flag when no new edge arrives with it
   a_flag_clear: assert property (@(posedge clk) disable iff (rst)
      (clr_mask[1] && edge_set[1] == 1'b0) |=> !flags_r[1])
      else $error("flag not cleared by write one");

   // The sequencer cannot drop the core enable while the pin is high
   a_seq_off: assert property (@(posedge clk) disable iff (rst)
      (seq_wr_core_off && regulator_enable_pin && !reg_wr) |=> $stable(core_en_r))
      else $error("core off while enable pin high");

   // Masking every edge silences the interrupt from the next edge on
   a_irq_mask: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == IRQ_MASK_ADDR
         && reg_wdata[EV_HI:EV_LO] == MASK_RST) |=> !irq_request)
      else $error("masked flag raised interrupt");

   // With the enable bit low and no wake request the core goes to sleep
   a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
      (pwr_r == SWER_RUN && !core_en_r && !wake_req) |=> in_sleep)
      else $error("sleep not entered");

   // Sleep holds until a wake request shows up
   a_sleep_held: assert property (@(posedge clk) disable iff (rst)
      (pwr_r == SWER_SLEEP && !wake_req) |=> in_sleep)
      else $error("left sleep without request");

   // Normal operation holds while the enable bit or a wake request stands
   a_run_held: assert property (@(posedge clk) disable iff (rst)
      (pwr_r == SWER_RUN && (core_en_r || wake_req)) |=> core_regulator_on)
      else $error("core dropped while held");

   // A pulse only names events whose sequence select bit was set
   a_seq_sel_only: assert property (@(posedge clk) disable iff (rst)
      seq_request |-> ((seq_event & ~$past(seq_sel_r)) == 6'h00))
      else $error("unselected event scheduled");

   // A flag that was already latched does not schedule again
   a_seq_no_repeat: assert property (@(posedge clk) disable iff (rst)
      seq_request |-> ((seq_event & $past(flags_r)) == 6'h00))
      else $error("old flag scheduled again");

   // A latched flag only drops through a write of one
   a_flag_hold: assert property (@(posedge clk) disable iff (rst)
      (flags_r != 6'h00) |=> (($past(flags_r) & ~$past(clr_mask) & ~flags_r) == 6'h00))
      else $error("flag lost without clear");

   // Every detected edge is latched, even against a clear
   a_flag_each: assert property (@(posedge clk) disable iff (rst)
      (edge_set != 6'h00) |=> (($past(edge_set) & ~flags_r) == 6'h00))
      else $error("edge not latched");

   // The pin keeps raising its flag while asleep
   a_pin_live: assert property (@(posedge clk) disable iff (rst)
      (in_sleep && pin_wake_signal && !sig_prev_r[1]) |=> flags_r[PIN_RISE_BIT-EV_LO])
      else $error("pin edge lost in sleep");

   // With the pin low the sequencer can clear the enable bit
   a_core_off_ok: assert property (@(posedge clk) disable iff (rst)
      (seq_wr_core_off && !regulator_enable_pin
         && !(reg_wr && reg_addr == CORE_CTRL_ADDR)) |=> !core_en_r)
      else $error("sequencer core off ignored");

   // A host write lands in the enable bit
   a_core_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == CORE_CTRL_ADDR) |=> core_en_r == $past(reg_wdata[CORE_EN_BIT]))
      else $error("core enable write lost");

   // Wake select takes bits 7..2 of the written word
   a_wake_sel_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == WAKE_SEL_ADDR) |=> wake_sel_r == $past(reg_wdata[EV_HI:EV_LO]))
      else $error("wake select write lost");

   // Sequence select takes the same bits
   a_seq_sel_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == SEQ_SEL_ADDR) |=> seq_sel_r == $past(reg_wdata[EV_HI:EV_LO]))
      else $error("sequence select write lost");

   // An unmasked edge raises the interrupt on the next edge
   a_irq_edge: assert property (@(posedge clk) disable iff (rst)
      (|(edge_set & ~irq_mask_r) && !(reg_wr && reg_addr == IRQ_MASK_ADDR)) |=> irq_request)
      else $error("unmasked edge gave no interrupt");

   // The interrupt stays up until a clear or a mask change
   a_irq_hold: assert property (@(posedge clk) disable iff (rst)
      (irq_request && clr_mask == 6'h00
         && !(reg_wr && reg_addr == IRQ_MASK_ADDR)) |=> irq_request)
      else $error("interrupt dropped by itself");

   // Wake select reads back in bits 7..2
   a_rd_wake: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == WAKE_SEL_ADDR) |=> reg_rdata == {8'h00, $past(wake_sel_r), 2'b00})
      else $error("wake select readback wrong");

   // Sequence select reads back in the same bits
   a_rd_seq: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == SEQ_SEL_ADDR) |=> reg_rdata == {8'h00, $past(seq_sel_r), 2'b00})
      else $error("sequence select readback wrong");

   // Latched flags read back in bits 7..2
   a_rd_flags: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == TRIG_FLG_ADDR) |=> reg_rdata == {8'h00, $past(flags_r), 2'b00})
      else $error("flag readback wrong");

   // The enable bit reads back in bit 0
   a_rd_core: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == CORE_CTRL_ADDR) |=> reg_rdata == {15'h0000, $past(core_en_r)})
      else $error("core enable readback wrong");

   // A pulse always names at least one event
   a_seq_nonzero: assert property (@(posedge clk) disable iff (rst)
      seq_request |-> seq_event != 6'h00)
      else $error("sequence pulse with no event");

endmodule // swer_router

// *** swer_far_side.sv ***
// Far-side model: jack, pin and clamp levels plus the regulator pin.
// Assumes the bench asks for levels; they move just after clk rises.
module swer_far_side (
   // Clock and requested levels
   input  wire logic       clk,
   input  wire logic [3:0] want,
   // Levels toward the router
   output logic            jack,
   output logic            pin,
   output logic            clamp,
   output logic            ena_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Levels only move on the clock, so each edge is sampled once; the bench asks for
   // all low through reset, so the first edge after release is a deliberate one
   always @(posedge clk) {ena_pin, clamp, pin, jack} <= want;
endmodule // swer_far_side

// *** swer_router_tb.sv ***
// Bench for swer_router: register port, edge routing and sleep control.
// Assumes a 25 MHz clock and the far-side model in swer_far_side.sv.
module swer_router_tb import swer_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, core_off = 0, rd_d = 0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
   logic [3:0]  want = 4'h0;
   logic        jack, pin, clamp, ena_pin, seq_request, core_on, in_sleep, irq;
   logic [5:0]  seq_event;
   logic [7:0]  lfsr = 8'h27;
   logic [15:0] rq[$];
   logic [5:0]  sq[$];
   int          error_cnt = 0, n_tests = 0;
   // 25 MHz clock
   initial forever #20 clk = ~clk;
   swer_far_side far (.clk(clk), .want(want), .jack(jack), .pin(pin), .clamp(clamp),
      .ena_pin(ena_pin));
   swer_router DUT (.clk(clk), .rst(rst), .jack_detect_signal(jack),
      .pin_wake_signal(pin), .mic_clamp_status(clamp), .regulator_enable_pin(ena_pin),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .seq_wr_core_off(core_off), .seq_request(seq_request),
      .seq_event(seq_event), .core_regulator_on(core_on), .in_sleep(in_sleep),
      .irq_request(irq));
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read result is noted here and judged by the scoreboard
   task automatic rd(logic [15:0] a, logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // Edge needs two clocks to reach the flag; the pulse comes on that same clock
   task automatic lvl(logic [3:0] w, int n);
      @(posedge clk);
      want <= w;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic off();
      @(posedge clk);
      core_off <= 1'b1;
      @(posedge clk);
      core_off <= 1'b0;
      repeat (3) @(negedge clk);
   endtask
   function automatic logic [7:0] nxt(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Scoreboard: a pulse with no note pending is itself a mismatch
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk) begin
      if (rd_d) chk("rdata", rq.pop_front(), reg_rdata);
      if (seq_request) chk("seq_event", sq.size() ? 16'(sq.pop_front()) : 16'hFFFF,
         16'(seq_event));
   end
   // Watchdog, far beyond the 150 or so cycles the tests need
   initial begin
      #40000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(WAKE_SEL_ADDR, 16'h0000);
      rd(SEQ_SEL_ADDR, 16'h0000);
      rd(IRQ_MASK_ADDR, 16'h00FC);
      rd(CORE_CTRL_ADDR, 16'h0001);
      rd(16'h0123, 16'h0000);
      repeat (4) begin
         lfsr = nxt(lfsr);
         wr(WAKE_SEL_ADDR, {8'hFF, lfsr});
         rd(WAKE_SEL_ADDR, {8'h00, lfsr & 8'hFC});
         wr(SEQ_SEL_ADDR, {8'h00, ~lfsr});
         rd(SEQ_SEL_ADDR, {8'h00, ~lfsr & 8'hFC});
      end
      $display("test registers done");
      wr(WAKE_SEL_ADDR, 16'h0000);
      wr(SEQ_SEL_ADDR, 16'h00FC);
      for (int i = 0; i < 6; i++) begin
         sq.push_back(6'h01 << i);
         lvl(want ^ (4'h1 << (i / 2)), 4);
      end
      rd(TRIG_FLG_ADDR, 16'h00FC);
      @(negedge clk);
      chk("irq_masked", 16'h0000, 16'(irq));
      wr(IRQ_MASK_ADDR, 16'h0000);
      @(negedge clk);
      chk("irq", 16'h0001, 16'(irq));
      wr(TRIG_FLG_ADDR, 16'h00FC);
      rd(TRIG_FLG_ADDR, 16'h0000);
      @(negedge clk);
      chk("irq_clear", 16'h0000, 16'(irq));
      $display("test sequence done");
      wr(WAKE_SEL_ADDR, 16'h0004);
      wr(CORE_CTRL_ADDR, 16'h0000);
      repeat (3) @(negedge clk);
      chk("in_sleep", 16'h0001, 16'(in_sleep));
      lvl(4'h2, 5);
      chk("in_sleep", 16'h0001, 16'(in_sleep));
      lvl(4'h3, 5);
      chk("core_on", 16'h0001, 16'(core_on));
      wr(TRIG_FLG_ADDR, 16'h00FC);
      repeat (3) @(negedge clk);
      chk("in_sleep", 16'h0001, 16'(in_sleep));
      lvl(4'hB, 5);
      chk("core_on", 16'h0001, 16'(core_on));
      wr(CORE_CTRL_ADDR, 16'h0001);
      off();
      chk("core_on", 16'h0001, 16'(core_on));
      rd(CORE_CTRL_ADDR, 16'h0001);
      lvl(4'h3, 4);
      chk("in_sleep", 16'h0000, 16'(in_sleep));
      off();
      chk("in_sleep", 16'h0001, 16'(in_sleep));
      // Wake on a jack fall, then set the enable bit before clearing the flags
      wr(WAKE_SEL_ADDR, 16'h0008);
      lvl(4'h2, 5);
      chk("core_on", 16'h0001, 16'(core_on));
      wr(CORE_CTRL_ADDR, 16'h0001);
      wr(TRIG_FLG_ADDR, 16'h00FC);
      repeat (3) @(negedge clk);
      chk("in_sleep", 16'h0000, 16'(in_sleep));
      $display("test sleep done");
      chk("pending", 16'h0000, 16'(sq.size() + rq.size()));
      print_verdict();
   end
endmodule // swer_router_tb
